// *** verilog/dccc_pkg.sv ***
// package for the conversion clock and sequence controller
// assumes one 100 MHz core clock; all analog parts sit outside
package dccc_pkg;
    localparam int unsigned CORE_CLK_HZ = 100_000_000;
    // register offsets
    localparam logic [4:0] REG_RESULT_LO = 5'h00;
    localparam logic [4:0] REG_RESULT_HI = 5'h01;
    localparam logic [4:0] REG_FAULT = 5'h02;
    localparam logic [4:0] REG_CLKDIV = 5'h03;
    localparam logic [4:0] REG_GAIN_MUX = 5'h04;
    localparam logic [4:0] REG_SOFT_RST = 5'h06;
    localparam logic [4:0] REG_REF_OSC = 5'h07;
    // field positions
    localparam int unsigned CLKDIV_LSB_FIRST_BIT = 2;
    localparam int unsigned CLKDIV_BINARY_BIT = 3;
    localparam int unsigned GAIN_MUX_START_BIT = 7;
    localparam int unsigned REF_OSC_FOR_REF_BIT = 5;
    localparam int unsigned REF_OSC_ON_BIT = 4;
    localparam int unsigned REF_ON_BIT = 3;
    localparam int unsigned REF_BUF_ON_BIT = 2;
    localparam int unsigned MUX_SWAP_BIT = 2;
    localparam int unsigned MUX_SINGLE_BIT = 3;
    // reset values: everything clears to zero
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    // reference level codes; zero is the reset choice
    localparam logic [1:0] REF_SEL_2V5 = 2'h0;
    localparam logic [1:0] REF_SEL_2V048 = 2'h1;
    localparam logic [1:0] REF_SEL_1V15 = 2'h2;
    // cycle counts in divided clocks; the start pin hold counts undivided pin clock rising edges
    localparam logic [5:0] CONV_CYCLES = 6'h30;
    localparam logic [5:0] PGA_CYCLES = 6'h24;
    localparam logic [5:0] CAPTURE_END = 6'h0C;
    localparam logic [5:0] AUTOZERO_END = 6'h18;
    localparam logic [1:0] START_DELAY_TICKS = 2'h2;
    localparam logic [1:0] PIN_HOLD_CLKS = 2'h2;
    localparam int unsigned RESULT_W = 12;
    localparam int unsigned FAULT_W = 4;

    typedef enum logic [1:0] {
        DCCC_IDLE,
        DCCC_WAIT,
        DCCC_PGA,
        DCCC_SAR
    } dccc_phase_t;

    typedef enum logic [1:0] {
        DCCC_STEP_CAPTURE,
        DCCC_STEP_AUTOZERO,
        DCCC_STEP_AMPLIFY,
        DCCC_STEP_NONE
    } dccc_step_t;

    typedef struct packed {
        logic [1:0] div_sel;
        logic lsb_first;
        logic binary;
        logic [2:0] gain;
        logic [3:0] mux;
        logic osc_for_ref;
        logic osc_on;
        logic ref_on;
        logic buf_on;
        logic [1:0] ref_sel;
        logic soft_rst;
    } dccc_cfg_t;

    typedef struct packed {
        dccc_cfg_t cfg;
        logic [RESULT_W-1:0] result;
        logic overload;
        logic [FAULT_W-1:0] faults;
        logic [FAULT_W-1:0] flt_acc;
        logic conv_clk_q;
        logic [2:0] div_cnt;
        logic [1:0] wait_cnt;
        logic pin_q;
        logic pin_armed;
        logic [1:0] pin_hold;
        dccc_phase_t phase;
        logic [5:0] cyc;
        logic [RESULT_W-1:0] sar;
        logic [3:0] bit_idx;
        logic [7:0] rdata;
    } dccc_state_t;
endpackage

// *** verilog/dccc_top.sv ***
// conversion clock division, 48-cycle sequencer, gain/mux and fault capture
// assumes all pins synchronous to i_core_clk; the serial port decodes
// instructions outside and hands over direct-mode starts as a pulse
//
// Functional notes
// - divided clock is the pin clock divided by 1, 2, 4 or 8.
// - divide select lives in register 3, same for both clock sources.
// - pin is output when drive pin high or oscillator bit set.
// - internal clock always sensed at the pin itself.
// - oscillator clocks reference when its reference bit and the reference-on bit are both set.
// - amplifier and converter biased only during their phases.
// - reference buffer output floats while disabled.
// - serial clock independent of conversion clock.
// - reference level selectable; 2.5 V after reset.
// - gain code from register 4 picks one of eight gains.
// - input switches decoded from four-bit channel field.
// - swap bit exchanges differential inputs.
// - result lsb is overload flag, OR of all fault comparators.
// - register 2 records which faults occurred.
// - twos complement result by default, msb or lsb first.
// - differential codes span -2048 to 2047.
// - single-ended codes span 0 to 2047.
// - a conversion lasts 48 divided clocks.
// - first 36 cycles capture, auto-zero, then amplify.
// - last 12 cycles decide one result bit each.
// - start on direct-mode instruction or register 4 start bit.
// - direct start begins on second divided falling edge after.
// - reset, start, oscillator are pin OR bit; start pin held two clocks.
// - busy high while converting.
// - master reset clears every register.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dccc_top
    import dccc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_reset_pin,
    input wire logic [4:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_direct_start,
    input wire logic [6:0] i_direct_code,
    input wire logic i_convert_pin,
    input wire logic i_osc_drive_pin,
    input wire logic i_osc_clk,
    input wire logic i_conv_clk_in,
    output logic o_conv_clk_out,
    output logic o_conv_clk_oe_n,
    output logic o_osc_en,
    output logic o_ref_clk_osc,
    output logic o_ref_en,
    output logic [1:0] o_ref_sel,
    output logic o_ref_buf_en,
    output logic o_ref_buf_hiz,
    output logic o_div_tick,
    output logic [2:0] o_gain_code,
    output logic [7:0] o_pos_line,
    output logic [7:0] o_neg_line,
    output logic o_neg_common,
    output logic o_pga_bias_en,
    output logic o_sar_bias_en,
    output logic [1:0] o_pga_step,
    output logic [RESULT_W-1:0] o_dac_code,
    input wire logic i_sar_cmp,
    input wire logic [FAULT_W-1:0] i_fault,
    output logic o_lsb_first,
    output logic o_busy
);
    dccc_state_t st_r;
    dccc_state_t st_nxt;
    logic rst;
    logic conv_fall;
    logic conv_rise;
    logic div_tick;
    logic [2:0] div_max;
    logic start_req;
    logic [RESULT_W-1:0] trial;
    logic [RESULT_W-1:0] coded;

    assign rst = i_srst | i_reset_pin | st_r.cfg.soft_rst;
    // pin sampled, never the oscillator directly, so shared lines match
    assign conv_fall = st_r.conv_clk_q & ~i_conv_clk_in;
    assign conv_rise = ~st_r.conv_clk_q & i_conv_clk_in;
    assign div_max = 3'((4'h1 << st_r.cfg.div_sel) - 4'h1);
    assign div_tick = conv_fall && (st_r.div_cnt == div_max);
    assign trial = st_r.sar | (RESULT_W'(1) << st_r.bit_idx);
    // sar yields offset binary; msb flip gives twos complement
    assign coded = {st_r.sar[RESULT_W-1] ^ ~st_r.cfg.binary,
        st_r.sar[RESULT_W-2:0]};

    always_comb begin
        st_nxt = st_r;
        start_req = 1'b0;
        st_nxt.conv_clk_q = i_conv_clk_in;
        st_nxt.pin_q = i_convert_pin;
        st_nxt.rdata = REG_RESET_VAL;
        // divider counts falling edges of the pin clock
        if (conv_fall) begin
            st_nxt.div_cnt = div_tick ? 3'h0 : st_r.div_cnt + 3'h1;
        end
        // start pin: rising edge, then must stay high two clock periods
        if (i_convert_pin && !st_r.pin_q) begin
            st_nxt.pin_armed = 1'b1;
            st_nxt.pin_hold = 2'h0;
        end else if (!i_convert_pin) begin
            st_nxt.pin_armed = 1'b0;
        end else if (st_r.pin_armed && conv_rise) begin
            if (st_r.pin_hold + 2'h1 == PIN_HOLD_CLKS) begin
                start_req = 1'b1;
                st_nxt.pin_armed = 1'b0;
            end else begin
                st_nxt.pin_hold = st_r.pin_hold + 2'h1;
            end
        end
        // register writes
        if (i_wr) begin
            case (i_addr)
                REG_CLKDIV: begin
                    st_nxt.cfg.div_sel = i_wdata[1:0];
                    st_nxt.cfg.lsb_first = i_wdata[CLKDIV_LSB_FIRST_BIT];
                    st_nxt.cfg.binary = i_wdata[CLKDIV_BINARY_BIT];
                end
                REG_GAIN_MUX: begin
                    st_nxt.cfg.gain = i_wdata[6:4];
                    st_nxt.cfg.mux = i_wdata[3:0];
                    if (i_wdata[GAIN_MUX_START_BIT]) begin
                        start_req = 1'b1;
                    end
                end
                REG_SOFT_RST: begin
                    st_nxt.cfg.soft_rst = i_wdata[0];
                end
                REG_REF_OSC: begin
                    st_nxt.cfg.osc_for_ref = i_wdata[REF_OSC_FOR_REF_BIT];
                    st_nxt.cfg.osc_on = i_wdata[REF_OSC_ON_BIT];
                    st_nxt.cfg.ref_on = i_wdata[REF_ON_BIT];
                    st_nxt.cfg.buf_on = i_wdata[REF_BUF_ON_BIT];
                    st_nxt.cfg.ref_sel = i_wdata[1:0];
                end
                default: begin
                end
            endcase
        end
        // direct-mode instruction loads gain and channel, then starts
        // serial side has its own clock; only a core-domain pulse arrives
        if (i_direct_start) begin
            st_nxt.cfg.gain = i_direct_code[6:4];
            st_nxt.cfg.mux = i_direct_code[3:0];
            start_req = 1'b1;
        end
        if (i_rd) begin
            case (i_addr)
                REG_RESULT_LO: st_nxt.rdata = {coded_lo(st_r.result), 3'h0, st_r.overload};
                REG_RESULT_HI: st_nxt.rdata = st_r.result[RESULT_W-1:4];
                REG_FAULT: st_nxt.rdata = {4'h0, st_r.faults};
                REG_CLKDIV: st_nxt.rdata = {4'h0, st_r.cfg.binary, st_r.cfg.lsb_first,
                    st_r.cfg.div_sel};
                REG_GAIN_MUX: st_nxt.rdata = {1'b0, st_r.cfg.gain, st_r.cfg.mux};
                REG_REF_OSC: st_nxt.rdata = {2'h0, st_r.cfg.osc_for_ref, st_r.cfg.osc_on,
                    st_r.cfg.ref_on, st_r.cfg.buf_on, st_r.cfg.ref_sel};
                default: st_nxt.rdata = REG_RESET_VAL;
            endcase
        end
        // sequencer; a start while busy is ignored
        case (st_r.phase)
            DCCC_IDLE: begin
                if (start_req) begin
                    st_nxt.phase = DCCC_WAIT;
                    st_nxt.wait_cnt = 2'h0;
                end
            end
            DCCC_WAIT: begin
                if (div_tick) begin
                    if (st_r.wait_cnt + 2'h1 == START_DELAY_TICKS) begin
                        st_nxt.phase = DCCC_PGA;
                        st_nxt.cyc = 6'h0;
                        st_nxt.sar = '0;
                        st_nxt.flt_acc = '0;
                        st_nxt.bit_idx = 4'(RESULT_W - 1);
                    end else begin
                        st_nxt.wait_cnt = st_r.wait_cnt + 2'h1;
                    end
                end
            end
            DCCC_PGA: begin
                st_nxt.flt_acc = st_r.flt_acc | i_fault;
                if (div_tick) begin
                    st_nxt.cyc = st_r.cyc + 6'h1;
                    if (st_r.cyc == PGA_CYCLES - 6'h1) begin
                        st_nxt.phase = DCCC_SAR;
                    end
                end
            end
            DCCC_SAR: begin
                st_nxt.flt_acc = st_r.flt_acc | i_fault;
                if (div_tick) begin
                    st_nxt.cyc = st_r.cyc + 6'h1;
                    if (i_sar_cmp) begin
                        st_nxt.sar = trial;
                    end
                    st_nxt.bit_idx = st_r.bit_idx - 4'h1;
                    if (st_r.cyc == CONV_CYCLES - 6'h1) begin
                        st_nxt.phase = DCCC_IDLE;
                    end
                end
            end
            default: begin
                st_nxt.phase = DCCC_IDLE;
            end
        endcase
        // result and flags land together with busy falling
        if (st_r.phase == DCCC_SAR && div_tick && st_r.cyc == CONV_CYCLES - 6'h1) begin
            st_nxt.result = {coded[RESULT_W-1:1], coded[0] | (i_sar_cmp &&
                st_r.bit_idx == 4'h0)};
            if (i_sar_cmp) begin
                st_nxt.result = {trial[RESULT_W-1] ^ ~st_r.cfg.binary, trial[RESULT_W-2:0]};
            end
            st_nxt.faults = st_r.flt_acc | i_fault;
            st_nxt.overload = |(st_r.flt_acc | i_fault);
        end
    end

    function automatic logic [3:0] coded_lo(input logic [RESULT_W-1:0] r);
        coded_lo = r[3:0];
    endfunction

    always_ff @(posedge i_core_clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // pin direction and oscillator enables
    assign o_osc_en = i_osc_drive_pin | st_r.cfg.osc_on |
        o_ref_clk_osc;
    assign o_conv_clk_oe_n = ~(i_osc_drive_pin | st_r.cfg.osc_on);
    assign o_conv_clk_out = i_osc_clk;
    assign o_ref_clk_osc = st_r.cfg.osc_for_ref & st_r.cfg.ref_on;
    assign o_ref_en = st_r.cfg.ref_on;
    assign o_ref_sel = st_r.cfg.ref_sel;
    assign o_ref_buf_en = st_r.cfg.buf_on;
    assign o_ref_buf_hiz = ~st_r.cfg.buf_on;
    assign o_div_tick = div_tick;
    assign o_gain_code = st_r.cfg.gain;
    assign o_lsb_first = st_r.cfg.lsb_first;
    assign o_rdata = st_r.rdata;
    assign o_busy = (st_r.phase == DCCC_PGA) || (st_r.phase == DCCC_SAR);
    assign o_pga_bias_en = (st_r.phase == DCCC_PGA);
    assign o_sar_bias_en = (st_r.phase == DCCC_SAR);
    assign o_dac_code = (st_r.phase == DCCC_SAR) ? trial : '0;
    // capture, auto-zero, amplify split evenly; gain does not change it
    always_comb begin
        if (st_r.phase != DCCC_PGA) begin
            o_pga_step = DCCC_STEP_NONE;
        end else if (st_r.cyc < CAPTURE_END) begin
            o_pga_step = DCCC_STEP_CAPTURE;
        end else if (st_r.cyc < AUTOZERO_END) begin
            o_pga_step = DCCC_STEP_AUTOZERO;
        end else begin
            o_pga_step = DCCC_STEP_AMPLIFY;
        end
    end

    // channel decode: one loop over the eight input lines
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_line
            logic se;
            logic swp;
            logic even;
            logic odd;
            assign se = st_r.cfg.mux[MUX_SINGLE_BIT];
            assign swp = st_r.cfg.mux[MUX_SWAP_BIT];
            assign even = ((gi % 2) == 0) && (st_r.cfg.mux[1:0] == 2'(gi / 2));
            assign odd = ((gi % 2) == 1) && (st_r.cfg.mux[1:0] == 2'(gi / 2));
            assign o_pos_line[gi] = se ? (st_r.cfg.mux[2:0] == 3'(gi)) :
                (swp ? odd : even);
            assign o_neg_line[gi] = se ? 1'b0 : (swp ? even : odd);
        end
    endgenerate
    assign o_neg_common = st_r.cfg.mux[MUX_SINGLE_BIT];
endmodule
`default_nettype wire

// *** verif/dccc_monitor.sv ***
// checker for the conversion sequencer, bound onto the top module
// assumes one core clock; either synchronous reset clears the sequence
`timescale 1ns/1ps
`default_nettype none
module dccc_monitor
    import dccc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_reset_pin,
    input wire logic i_osc_drive_pin,
    input wire logic o_conv_clk_oe_n,
    input wire logic o_osc_en,
    input wire logic o_ref_clk_osc,
    input wire logic o_ref_en,
    input wire logic o_ref_buf_en,
    input wire logic o_ref_buf_hiz,
    input wire logic o_div_tick,
    input wire logic o_pga_bias_en,
    input wire logic o_sar_bias_en,
    input wire logic [1:0] o_pga_step,
    input wire logic [RESULT_W-1:0] o_dac_code,
    input wire logic o_busy
);
    logic [5:0] ticks_r;
    // divided ticks since busy rose; cleared while idle
    always_ff @(posedge i_core_clk) begin
        if (i_srst || i_reset_pin || !o_busy) begin
            ticks_r <= 6'h00;
        end else if (o_div_tick) begin
            ticks_r <= ticks_r + 6'h01;
        end
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_srst || i_reset_pin);
    AST_PIN_DRIVE: assert property (i_osc_drive_pin |-> !o_conv_clk_oe_n && o_osc_en)
        else $error("pin not driven while drive pin high");
    AST_REF_CLK: assert property (o_ref_clk_osc |-> o_osc_en && o_ref_en)
        else $error("reference clocked without oscillator");
    AST_BUF_FLOAT: assert property (o_ref_buf_hiz == !o_ref_buf_en)
        else $error("buffer float state wrong");
    AST_IDLE_BIAS: assert property (!o_busy |->
        !o_pga_bias_en && !o_sar_bias_en && o_dac_code == '0)
        else $error("bias or trial word active while idle");
    AST_STEP_MAP: assert property (o_pga_bias_en == (o_pga_step != 2'h3))
        else $error("amplifier step and bias disagree");
    AST_FIRST_CYCLE: assert property ($rose(o_busy) |->
        o_pga_bias_en && o_pga_step == 2'h0)
        else $error("conversion not starting with capture");
    AST_START_TICK: assert property ($rose(o_busy) |-> $past(o_div_tick))
        else $error("busy rose away from a divided tick");
    AST_SAR_AT_36: assert property ($rose(o_sar_bias_en) |->
        ticks_r == 6'h24 && $fell(o_pga_bias_en))
        else $error("approximation phase not after 36 cycles");
    AST_MSB_TRIAL: assert property ($rose(o_sar_bias_en) |-> o_dac_code == 12'h800)
        else $error("first trial word not msb");
    AST_LEN_48: assert property ($fell(o_busy) |-> ticks_r == 6'h30)
        else $error("conversion not 48 divided cycles");
endmodule
bind dccc_top dccc_monitor u_mon (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_reset_pin(i_reset_pin),
    .i_osc_drive_pin(i_osc_drive_pin), .o_conv_clk_oe_n(o_conv_clk_oe_n), .o_osc_en(o_osc_en),
    .o_ref_clk_osc(o_ref_clk_osc), .o_ref_en(o_ref_en), .o_ref_buf_en(o_ref_buf_en),
    .o_ref_buf_hiz(o_ref_buf_hiz), .o_div_tick(o_div_tick), .o_pga_bias_en(o_pga_bias_en),
    .o_sar_bias_en(o_sar_bias_en), .o_pga_step(o_pga_step), .o_dac_code(o_dac_code),
    .o_busy(o_busy)
);
`default_nettype wire

// *** verif/dccc_analog_model.sv ***
// far side: external clock source, oscillator and sar comparator
// assumes half periods counted in core cycles; runs free, never stops
`timescale 1ns/1ps
`default_nettype none
module dccc_analog_model #(
    parameter int EXT_HALF = 20,
    parameter int OSC_HALF = 25
) (
    input wire logic i_core_clk,
    input wire logic i_conv_clk_out,
    input wire logic i_conv_clk_oe_n,
    input wire logic [11:0] i_dac_code,
    input wire logic [11:0] i_target,
    output logic o_pin,
    output logic o_osc_clk,
    output logic o_sar_cmp
);
    logic ext_r = 1'b0;
    logic osc_r = 1'b0;
    int ext_cnt = 0;
    int osc_cnt = 0;
    // 2.5 MHz at divide 1, the fastest allowed divided clock
    always @(posedge i_core_clk) begin
        ext_cnt <= (ext_cnt == EXT_HALF - 1) ? 0 : ext_cnt + 1;
        if (ext_cnt == EXT_HALF - 1) ext_r <= ~ext_r;
        osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
        if (osc_cnt == OSC_HALF - 1) osc_r <= ~osc_r;
    end
    assign o_osc_clk = osc_r;
    // one wire, two drivers: device wins while its enable is low
    assign o_pin = i_conv_clk_oe_n ? ext_r : i_conv_clk_out;
    // ideal input: keep a trial bit while not above the held level
    assign o_sar_cmp = (i_dac_code <= i_target);
endmodule
`default_nettype wire

// *** verif/dccc_tb_top.sv ***
// register-level tests of the conversion sequencer
// assumes the analog model on the pin clock, oscillator and comparator
`timescale 1ns/1ps
`default_nettype none
module dccc_tb_top;
    import dccc_pkg::*;
    logic i_core_clk = 1'b0;
    logic srst = 1'b1, rst_pin = 1'b0, wr = 1'b0, rd = 1'b0;
    logic dstart = 1'b0, cpin = 1'b0, drv = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00, rdata, rv, pos, neg, e8;
    logic [6:0] dcode = 7'h00;
    logic [3:0] flt = 4'h0;
    logic [11:0] tgt = 12'h000, dac;
    logic [1:0] ref_sel;
    logic [2:0] gain;
    logic osc_clk, pin, cout, oe_n, cmp, busy, lsbf, ncom, hiz, rbuf, osc_en, ref_clk, ref_en;
    logic [11:0] tg [4] = '{12'h000, 12'hFFF, 12'hA5C, 12'h3C1};
    logic [20:0] mux_tab [3] = '{{4'h0, 8'h01, 8'h02, 1'b0}, {4'h1, 8'h04, 8'h08, 1'b0},
                                 {4'h5, 8'h08, 8'h04, 1'b0}};
    int n_fail = 0, checks_done = 0, n;
    always #5 i_core_clk = ~i_core_clk;
    dccc_top u_dut (.i_core_clk(i_core_clk), .i_srst(srst), .i_reset_pin(rst_pin), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_direct_start(dstart),
        .i_direct_code(dcode), .i_convert_pin(cpin), .i_osc_drive_pin(drv), .i_osc_clk(osc_clk),
        .i_conv_clk_in(pin), .o_conv_clk_out(cout), .o_conv_clk_oe_n(oe_n), .o_osc_en(osc_en),
        .o_ref_clk_osc(ref_clk), .o_ref_en(ref_en), .o_ref_sel(ref_sel), .o_ref_buf_en(rbuf),
        .o_ref_buf_hiz(hiz), .o_div_tick(), .o_gain_code(gain), .o_pos_line(pos),
        .o_neg_line(neg), .o_neg_common(ncom), .o_pga_bias_en(), .o_sar_bias_en(),
        .o_pga_step(), .o_dac_code(dac),
        .i_sar_cmp(cmp), .i_fault(flt), .o_lsb_first(lsbf), .o_busy(busy));
    dccc_analog_model #(.EXT_HALF(20), .OSC_HALF(25)) u_far (.i_core_clk(i_core_clk),
        .i_conv_clk_out(cout), .i_conv_clk_oe_n(oe_n), .i_dac_code(dac), .i_target(tgt),
        .o_pin(pin), .o_osc_clk(osc_clk), .o_sar_cmp(cmp));
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_core_clk);
        wr <= 1'b0;
        @(negedge i_core_clk);
    endtask
    task automatic rreg(input logic [4:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_core_clk);
        rd <= 1'b0;
        @(negedge i_core_clk);
        d = rdata;
    endtask
    // how: 0 register start bit, 1 direct instruction, 2 start pin
    task automatic conv(input int how, input logic [11:0] t, input logic [3:0] f);
        int w;
        w = 0;
        @(posedge i_core_clk);
        tgt <= t;
        flt <= f;
        if (how == 0) wreg(REG_GAIN_MUX, 8'h80);
        else begin
            @(posedge i_core_clk);
            dcode <= 7'h25;
            dstart <= (how == 1);
            cpin <= (how == 2);
            @(posedge i_core_clk);
            dstart <= 1'b0;
        end
        while (busy !== 1'b1 && w < 2000) begin
            @(negedge i_core_clk);
            w++;
        end
        n = 0;
        while (busy === 1'b1 && n < 20000) begin
            @(negedge i_core_clk);
            n++;
        end
        @(posedge i_core_clk);
        flt <= 4'h0;
        cpin <= 1'b0;
    endtask
    task automatic res_chk(input logic [11:0] e, input logic [3:0] f);
        rreg(REG_RESULT_HI, rv);
        chk(rv, e[11:4]);
        rreg(REG_RESULT_LO, rv);
        chk(rv, {e[3:0], 3'h0, |f});
        rreg(REG_FAULT, rv);
        chk(rv, {4'h0, f});
    endtask
    initial begin
        repeat (12) @(posedge i_core_clk);
        srst <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            rreg(a[4:0], rv);
            chk(rv, REG_RESET_VAL);
        end
        rreg(5'h1F, rv);
        chk({rv, 6'h00, ref_sel}, {8'h00, 6'h00, REF_SEL_2V5});
        @(posedge i_core_clk);
        drv <= 1'b1;
        @(negedge i_core_clk);
        chk({oe_n, osc_en}, 2'h1);
        @(posedge i_core_clk);
        drv <= 1'b0;
        for (int i = 0; i < 64; i++) begin
            if (i[1:0] != 2'h3) begin
                wreg(REG_REF_OSC, i[7:0]);
                e8 = {i[1:0], i[3], i[5] & i[3], i[2], !i[2], i[4] | (i[5] & i[3]), !i[4]};
                chk({ref_sel, ref_en, ref_clk, rbuf, hiz, osc_en, oe_n}, e8);
                rreg(REG_REF_OSC, rv);
                chk(rv, i[7:0]);
            end
        end
        wreg(REG_REF_OSC, 8'h00);
        for (int g = 0; g < 8; g++) begin
            wreg(REG_GAIN_MUX, {1'b0, g[2:0], 4'h0});
            chk(gain, g[2:0]);
        end
        foreach (mux_tab[k]) begin
            wreg(REG_GAIN_MUX, {4'h0, mux_tab[k][20:17]});
            chk({pos, neg}, mux_tab[k][16:1]);
            chk(ncom, 1'b0);
        end
        wreg(REG_GAIN_MUX, 8'h0B);
        chk({pos, 7'h00, ncom}, {8'h08, 8'h01});
        for (int d = 0; d < 4; d++) begin
            wreg(REG_CLKDIV, d[7:0]);
            conv(0, tg[d], 4'h0);
            chk(n[15:0], 16'h0780 << d);
            res_chk({~tg[d][11], tg[d][10:0]}, 4'h0);
        end
        wreg(REG_CLKDIV, 8'h08);
        conv(1, 12'h5A3, 4'h9);
        chk(n[15:0], 16'h0780);
        res_chk(12'h5A3, 4'h9);
        rreg(REG_GAIN_MUX, rv);
        chk({rv, 5'h00, gain}, 16'h2502);
        wreg(REG_CLKDIV, 8'h04);
        chk(lsbf, 1'b1);
        conv(2, 12'h123, 4'h0);
        chk(n[15:0], 16'h0780);
        res_chk(12'h923, 4'h0);
        wreg(REG_REF_OSC, 8'h10);
        wreg(REG_CLKDIV, 8'h01);
        conv(0, 12'h7FF, 4'h0);
        chk(n[15:0], 16'h12C0);
        res_chk(12'hFFF, 4'h0);
        wreg(REG_GAIN_MUX, 8'h80);
        while (busy !== 1'b1) @(negedge i_core_clk);
        // host reads while converting; the read must not disturb the run
        rreg(REG_CLKDIV, rv);
        chk({rv, 7'h00, busy}, 16'h0101);
        @(posedge i_core_clk);
        rst_pin <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        rst_pin <= 1'b0;
        @(negedge i_core_clk);
        chk(busy, 1'b0);
        rreg(REG_REF_OSC, rv);
        chk(rv, 8'h00);
        wreg(REG_CLKDIV, 8'h03);
        wreg(REG_SOFT_RST, 8'h01);
        rreg(REG_CLKDIV, rv);
        chk(rv, 8'h00);
        results();
    end
    initial begin
        repeat (90000) @(posedge i_core_clk);
        n_fail++;
        results();
    end
endmodule
`default_nettype wire
